// ==== verilog/pll_cal_pkg.sv ====
// Shared constants, field layouts and types of the PLL calibration and sync controls
package pll_cal_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] LOCK_CAL_CTRL_IDX   = 12'h018;
    localparam logic [11:0] SYNC_DELAY_IDX      = 12'h019;
    localparam logic [11:0] STATUS_IDX          = 12'h01A;
    localparam logic [11:0] UPDATE_IDX          = 12'h232;
    localparam logic [11:0] LOCK_CAL_CTRL_ADDR  = 12'(LOCK_CAL_CTRL_IDX * 4);
    localparam logic [11:0] SYNC_DELAY_ADDR     = 12'(SYNC_DELAY_IDX * 4);
    localparam logic [11:0] STATUS_ADDR         = 12'(STATUS_IDX * 4);
    localparam logic [11:0] UPDATE_ADDR         = 12'(UPDATE_IDX * 4);
    localparam int unsigned UPDATE_BIT          = 0;

    typedef struct packed {
        logic [2:0] reserved;
        logic       lock_window;
        logic       lock_detect_off;
        logic [1:0] calibration_clock_ratio;
        logic       calibration_trigger;
    } lock_cal_ctrl_type;

    typedef struct packed {
        logic [1:0] sync_mode;
        logic [2:0] ref_delay;
        logic [2:0] reserved;
    } sync_delay_type;

    typedef struct packed {
        logic [4:0] reserved;
        logic       trigger_active;
        logic       cal_busy;
        logic       locked;
    } status_type;

    localparam logic [7:0] LOCK_CAL_CTRL_RST = 8'h06;
    localparam logic [7:0] SYNC_DELAY_RST    = 8'h00;

    // Action of the loop counters on a resync pin edge
    localparam logic [1:0] SYNC_NONE  = 2'h0;
    localparam logic [1:0] SYNC_ASYNC = 2'h1;
    localparam logic [1:0] SYNC_SYNC  = 2'h2;
    localparam logic [1:0] SYNC_NONE2 = 2'h3;

    // Lock detector thresholds in reference clock cycles
    localparam logic [7:0] LOCK_WINDOW_CYC = 8'h02;
    localparam logic [7:0] UNLOCK_CYC      = 8'h04;
    // Length of one calibration in calibration clock ticks
    localparam logic [7:0] CAL_TICKS       = 8'h10;

    // Pin synchroniser order {sync_n, fb, ref} and its reset levels
    localparam int unsigned PIN_COUNT = 3;
    localparam logic [2:0]  PIN_RST   = 3'h4;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b01,
        CAL_RUN  = 2'b10
    } cal_state_type;

endpackage

// ==== verilog/cal_clock_divider.sv ====
// Divider that makes the calibration clock from the reference clock
`timescale 1ns/1ns
module cal_clock_divider (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [1:0] ratio_i,
    output logic            tick_o,
    output logic            cal_clk_o
);

    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [3:0] mask;

    always_comb begin
        cnt_d = cnt_q + 4'h1;
        mask  = 4'((5'h02 << ratio_i) - 5'h01);
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // [RULE3] divide by power
    assign tick_o    = (cnt_q & mask) == mask;
    assign cal_clk_o = cnt_q[ratio_i];

    tick_div2_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE3]
        (tick_o && ratio_i == 2'h0) |=> !tick_o ##1 (tick_o || ratio_i != 2'h0))
        else $error("divide by 2 tick spacing wrong");

    tick_div16_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE3]
        ((tick_o && ratio_i == 2'h3) ##1 (ratio_i == 2'h3 && !tick_o)[*8]
            ##1 (ratio_i == 2'h3 && !tick_o)[*7]) |=> (tick_o || ratio_i != 2'h3))
        else $error("divide by 16 tick spacing wrong");

endmodule

// ==== verilog/pll_cal_sync_ctrl.sv ====
// Lock detect, calibration clock and trigger, resync action and reference delay controls
// Operation
// [RULE1] Lock detect runs at 0, off at 1
// [RULE2] Lock sets inside window, clears past threshold
// [RULE3] Calibration clock divides reference by 2..16
// [RULE4] Calibration starts on active trigger rising edge
// [RULE5] Controller ensures reference present before triggering
// [RULE6] Controller writes trigger 0, update, 1, update
// [RULE7] Written fields take effect on update bit
// [RULE8] Resync pin: none, async or sync counter reset
// [RULE9] Three-bit reference path delay, reset zero
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ns
module pll_calibration_sync_controls (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [11:0] avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        ref_phase_i,
    input  wire logic        fb_phase_i,
    input  wire logic        sync_n_i,
    output logic             locked_o,
    output logic             cal_clk_o,
    output logic             cal_start_o,
    output logic             cal_busy_o,
    output logic             ctr_arst_o,
    output logic             ctr_srst_o,
    output logic      [2:0]  ref_delay_o,
    output logic             lock_window_o
);

    // Bus slave
    logic        ack_q, ack_d, wr_fire, upd;
    logic [31:0] rdata_q, rdata_d;

    pll_cal_pkg::lock_cal_ctrl_type lock_buf_q, lock_buf_d, lock_act_q, lock_act_d;
    pll_cal_pkg::sync_delay_type    sync_buf_q, sync_buf_d, sync_act_q, sync_act_d;
    pll_cal_pkg::status_type        status;

    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign avs_readdata_o    = rdata_q;
    assign wr_fire           = avs_write_i & ack_q & avs_byteenable_i[0];
    assign upd               = wr_fire & (avs_address_i == pll_cal_pkg::UPDATE_ADDR)
                               & avs_writedata_i[pll_cal_pkg::UPDATE_BIT];

    always_comb begin
        ack_d   = (avs_read_i | avs_write_i) & ~ack_q;
        rdata_d = rdata_q;
        if (avs_read_i && !ack_q) begin
            unique case (avs_address_i)
                pll_cal_pkg::LOCK_CAL_CTRL_ADDR: rdata_d = {24'h000000, lock_buf_q};
                pll_cal_pkg::SYNC_DELAY_ADDR:    rdata_d = {24'h000000, sync_buf_q};
                pll_cal_pkg::STATUS_ADDR:        rdata_d = {24'h000000, status};
                default:                         rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // Buffered and active register sets
    always_comb begin
        lock_buf_d = lock_buf_q;
        sync_buf_d = sync_buf_q;
        lock_act_d = lock_act_q;
        sync_act_d = sync_act_q;
        if (wr_fire && avs_address_i == pll_cal_pkg::LOCK_CAL_CTRL_ADDR) begin
            lock_buf_d          = avs_writedata_i[7:0];
            lock_buf_d.reserved = 3'h0;
        end
        if (wr_fire && avs_address_i == pll_cal_pkg::SYNC_DELAY_ADDR) begin
            sync_buf_d          = avs_writedata_i[7:0];
            sync_buf_d.reserved = 3'h0;
        end
        // [RULE7] update copies buffer
        if (upd) begin
            lock_act_d = lock_buf_q;
            sync_act_d = sync_buf_q;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_buf_q <= pll_cal_pkg::LOCK_CAL_CTRL_RST;
            sync_buf_q <= pll_cal_pkg::SYNC_DELAY_RST;
            lock_act_q <= pll_cal_pkg::LOCK_CAL_CTRL_RST;
            sync_act_q <= pll_cal_pkg::SYNC_DELAY_RST;
        end else begin
            lock_buf_q <= lock_buf_d;
            sync_buf_q <= sync_buf_d;
            lock_act_q <= lock_act_d;
            sync_act_q <= sync_act_d;
        end
    end

    // [RULE9] reference path delay
    assign ref_delay_o   = sync_act_q.ref_delay;
    assign lock_window_o = lock_act_q.lock_window;

    update_copy_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE7]
        upd |=> (lock_act_q == $past(lock_buf_q) && sync_act_q == $past(sync_buf_q)))
        else $error("active set not loaded on update");
    hold_active_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE7]
        !upd |=> ($stable(lock_act_q) && $stable(sync_act_q)))
        else $error("active set changed without update");
    delay_out_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE9]
        upd |=> ref_delay_o == $past(sync_buf_q.ref_delay))
        else $error("reference delay not taken from update");

    // Pin synchronisers: three stages, level moves when stages two and three agree
    logic [2:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, rise, pins;

    assign pins = {sync_n_i, fb_phase_i, ref_phase_i};
    for (genvar g = 0; g < pll_cal_pkg::PIN_COUNT; g++) begin : g_pin
        assign lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
        assign rise[g]  = lvl_d[g] & ~lvl_q[g];
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q  <= pll_cal_pkg::PIN_RST;
            s2_q  <= pll_cal_pkg::PIN_RST;
            s3_q  <= pll_cal_pkg::PIN_RST;
            lvl_q <= pll_cal_pkg::PIN_RST;
        end else begin
            s1_q  <= pins;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    // Resync pin action on loop counters
    logic sync_fall, srst_q, srst_d;
    assign sync_fall = lvl_q[2] & ~lvl_d[2];

    always_comb begin
        // [RULE8] synchronous counter reset
        srst_d = sync_fall && (sync_act_q.sync_mode == pll_cal_pkg::SYNC_SYNC);
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            srst_q <= 1'b0;
        end else begin
            srst_q <= srst_d;
        end
    end

    // [RULE8] asynchronous counter reset
    assign ctr_arst_o = (sync_act_q.sync_mode == pll_cal_pkg::SYNC_ASYNC) & ~lvl_q[2];
    assign ctr_srst_o = srst_q;

    srst_mode_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE8]
        (sync_fall && sync_act_q.sync_mode == pll_cal_pkg::SYNC_SYNC) |=> ctr_srst_o)
        else $error("sync mode edge gave no counter reset");
    no_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE8]
        (sync_act_q.sync_mode[0] == sync_act_q.sync_mode[1])
            |-> (!ctr_arst_o && (!ctr_srst_o
                || $past(sync_act_q.sync_mode) == pll_cal_pkg::SYNC_SYNC)))
        else $error("counter reset in a do-nothing mode");
    arst_mode_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE8]
        (sync_act_q.sync_mode != pll_cal_pkg::SYNC_ASYNC) |-> !ctr_arst_o)
        else $error("async reset outside async mode");

    // Digital lock detector on synchronised phase detector input edges
    logic       pend_ref_q, pend_ref_d, pend_fb_q, pend_fb_d, locked_q, locked_d, diff_valid;
    logic [7:0] gap_q, gap_d, diff;

    always_comb begin
        pend_ref_d = pend_ref_q;
        pend_fb_d  = pend_fb_q;
        gap_d      = gap_q;
        locked_d   = locked_q;
        diff_valid = 1'b0;
        diff       = gap_q;
        // [RULE1] detector off
        if (lock_act_q.lock_detect_off) begin
            pend_ref_d = 1'b0;
            pend_fb_d  = 1'b0;
            gap_d      = 8'h00;
            locked_d   = 1'b0;
        end else begin
            if (rise[0] && rise[1]) begin
                pend_ref_d = 1'b0;
                pend_fb_d  = 1'b0;
                diff_valid = 1'b1;
                diff       = 8'h00;
            end else if (rise[0]) begin
                diff_valid = pend_fb_q;
                pend_fb_d  = 1'b0;
                pend_ref_d = ~pend_fb_q;
                gap_d      = 8'h00;
            end else if (rise[1]) begin
                diff_valid = pend_ref_q;
                pend_ref_d = 1'b0;
                pend_fb_d  = ~pend_ref_q;
                gap_d      = 8'h00;
            end else if (pend_ref_q || pend_fb_q) begin
                gap_d = (gap_q == 8'hFF) ? gap_q : gap_q + 8'h01;
                if (gap_q > pll_cal_pkg::UNLOCK_CYC) begin
                    locked_d = 1'b0;
                end
            end
            // [RULE2] lock hysteresis
            if (diff_valid && diff < pll_cal_pkg::LOCK_WINDOW_CYC) begin
                locked_d = 1'b1;
            end else if (diff_valid && diff > pll_cal_pkg::UNLOCK_CYC) begin
                locked_d = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend_ref_q <= 1'b0;
            pend_fb_q  <= 1'b0;
            gap_q      <= 8'h00;
            locked_q   <= 1'b0;
        end else begin
            pend_ref_q <= pend_ref_d;
            pend_fb_q  <= pend_fb_d;
            gap_q      <= gap_d;
            locked_q   <= locked_d;
        end
    end

    assign locked_o = locked_q;

    lock_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE1]
        lock_act_q.lock_detect_off |=> !locked_o)
        else $error("lock flag set while detector off");
    lock_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE2]
        (!lock_act_q.lock_detect_off && diff_valid && diff < pll_cal_pkg::LOCK_WINDOW_CYC)
            |=> locked_o)
        else $error("lock flag not set inside window");
    lock_keep_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE2]
        (locked_o && !lock_act_q.lock_detect_off && !(diff_valid
            && diff > pll_cal_pkg::UNLOCK_CYC) && gap_q <= pll_cal_pkg::UNLOCK_CYC)
            |=> locked_o)
        else $error("lock flag lost below threshold");

    // Calibration clock and sequencer
    logic                       cal_tick, cal_go;
    logic                       start_q, start_d;
    logic [7:0]                 ticks_q, ticks_d;
    pll_cal_pkg::cal_state_type cal_q, cal_d;

    cal_clock_divider u_div (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .ratio_i   (lock_act_q.calibration_clock_ratio),
        .tick_o    (cal_tick),
        .cal_clk_o (cal_clk_o)
    );

    // [RULE4] trigger rising edge
    assign cal_go = upd & lock_buf_q.calibration_trigger & ~lock_act_q.calibration_trigger;

    always_comb begin
        cal_d   = cal_q;
        ticks_d = ticks_q;
        start_d = cal_go;
        unique case (cal_q)
            pll_cal_pkg::CAL_IDLE: begin
                if (cal_go) begin
                    cal_d   = pll_cal_pkg::CAL_RUN;
                    ticks_d = 8'h00;
                end
            end
            pll_cal_pkg::CAL_RUN: begin
                if (cal_go) begin
                    ticks_d = 8'h00;
                end else if (cal_tick) begin
                    ticks_d = ticks_q + 8'h01;
                    if (ticks_q == pll_cal_pkg::CAL_TICKS - 8'h01) begin
                        cal_d = pll_cal_pkg::CAL_IDLE;
                    end
                end
            end
            default: begin
                cal_d   = pll_cal_pkg::CAL_IDLE;
                ticks_d = 8'h00;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cal_q   <= pll_cal_pkg::CAL_IDLE;
            ticks_q <= 8'h00;
            start_q <= 1'b0;
        end else begin
            cal_q   <= cal_d;
            ticks_q <= ticks_d;
            start_q <= start_d;
        end
    end

    assign cal_start_o = start_q;
    assign cal_busy_o  = (cal_q == pll_cal_pkg::CAL_RUN);

    assign status = '{reserved: 5'h00, trigger_active: lock_act_q.calibration_trigger,
                      cal_busy: cal_busy_o, locked: locked_q};

    cal_start_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE4]
        (upd && lock_buf_q.calibration_trigger && !lock_act_q.calibration_trigger)
            |=> (cal_start_o && cal_busy_o))
        else $error("trigger edge did not start calibration");
    cal_level_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // [RULE4]
        $past(lock_act_q.calibration_trigger) |-> !cal_start_o)
        else $error("calibration started on held trigger");
    bus_wait_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i) // Bus slave handshake
        ($rose(avs_read_i) || $rose(avs_write_i)) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("bus answer not on second cycle");

endmodule

// ==== bench/pll_calibration_sync_controls_bench.sv ====
// Self-checking bench for the PLL calibration and sync controls
`timescale 1ns/1ns
module pll_calibration_sync_controls_bench;
    logic        ref_clk_i;
    logic        rst_n_i;
    logic [11:0] avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0]  avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        ref_phase_i;
    logic        fb_phase_i;
    logic        sync_n_i;
    logic        locked_o;
    logic        cal_clk_o;
    logic        cal_start_o;
    logic        cal_busy_o;
    logic        ctr_arst_o;
    logic        ctr_srst_o;
    logic [2:0]  ref_delay_o;
    logic        lock_window_o;
    int          n_errors;
    int          checked;
    int          n_start;
    int          n_busy;
    int          n_srst;
    int          n_arst;
    logic [31:0] rd;
    int          per;

    pll_calibration_sync_controls u_pll_calibration_sync_controls (
        .ref_clk_i         (ref_clk_i),
        .rst_n_i           (rst_n_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .ref_phase_i       (ref_phase_i),
        .fb_phase_i        (fb_phase_i),
        .sync_n_i          (sync_n_i),
        .locked_o          (locked_o),
        .cal_clk_o         (cal_clk_o),
        .cal_start_o       (cal_start_o),
        .cal_busy_o        (cal_busy_o),
        .ctr_arst_o        (ctr_arst_o),
        .ctr_srst_o        (ctr_srst_o),
        .ref_delay_o       (ref_delay_o),
        .lock_window_o     (lock_window_o)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    // Event counters sampled mid-cycle where outputs are settled
    always @(negedge ref_clk_i) begin
        if (cal_start_o === 1'b1) n_start++;
        if (cal_busy_o === 1'b1) n_busy++;
        if (ctr_srst_o === 1'b1) n_srst++;
        if (ctr_arst_o === 1'b1) n_arst++;
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Holds the request until waitrequest is sampled low at a rising edge
    task automatic bus_access(input logic wr, input logic [11:0] addr, input logic [31:0] data,
                              input logic [3:0] be, output logic [31:0] rdata);
        @(posedge ref_clk_i);
        avs_address_i    <= addr;
        avs_writedata_i  <= data;
        avs_byteenable_i <= be;
        avs_write_i      <= wr;
        avs_read_i       <= ~wr;
        @(posedge ref_clk_i);
        while (avs_waitrequest_o !== 1'b0) begin
            @(posedge ref_clk_i);
        end
        rdata = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask

    task automatic bus_write(input logic [11:0] addr, input logic [7:0] data);
        logic [31:0] dummy;
        bus_access(1'b1, addr, {24'h000000, data}, 4'hF, dummy);
    endtask

    task automatic bus_read(input logic [11:0] addr, output logic [31:0] data);
        bus_access(1'b0, addr, 32'h00000000, 4'hF, data);
    endtask

    task automatic update();
        bus_write(pll_cal_pkg::UPDATE_ADDR, 8'h01);
        repeat (2) @(posedge ref_clk_i);
    endtask

    // Twelve-cycle frame: reference edge at 0, feedback edge at gap
    task automatic phase_frames(input int gap, input int frames);
        repeat (frames) begin
            for (int c = 0; c < 12; c++) begin
                @(posedge ref_clk_i);
                ref_phase_i <= (c < 2);
                fb_phase_i  <= (c >= gap && c < gap + 2);
            end
        end
        repeat (6) @(negedge ref_clk_i);
    endtask

    // Cycles between two rising edges of the calibration clock
    task automatic cal_period(output int p);
        int n;
        n = 0;
        @(negedge ref_clk_i);
        while (cal_clk_o !== 1'b0 && n < 100) begin n++; @(negedge ref_clk_i); end
        while (cal_clk_o !== 1'b1 && n < 100) begin n++; @(negedge ref_clk_i); end
        p = 0;
        while (cal_clk_o !== 1'b0 && p < 100) begin p++; @(negedge ref_clk_i); end
        while (cal_clk_o !== 1'b1 && p < 100) begin p++; @(negedge ref_clk_i); end
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        n_errors = 0;
        checked = 0;
        n_start = 0;
        n_busy = 0;
        n_srst = 0;
        n_arst = 0;
        rst_n_i = 1'b0;
        avs_address_i = 12'h000;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h00000000;
        avs_byteenable_i = 4'h0;
        ref_phase_i = 1'b0;
        fb_phase_i = 1'b0;
        sync_n_i = 1'b1;
        repeat (16) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        bus_read(pll_cal_pkg::LOCK_CAL_CTRL_ADDR, rd);
        check(rd, 32'h00000006);
        bus_read(pll_cal_pkg::SYNC_DELAY_ADDR, rd);
        check(rd, 32'h00000000);
        check({29'h0, ref_delay_o}, 32'h00000000);
        bus_read(12'h010, rd);
        check(rd, 32'h00000000);
        bus_write(pll_cal_pkg::SYNC_DELAY_ADDR, 8'h28);
        bus_access(1'b1, pll_cal_pkg::SYNC_DELAY_ADDR, 32'h000000FF, 4'h0, rd);
        repeat (3) @(negedge ref_clk_i);
        check({29'h0, ref_delay_o}, 32'h00000000);
        bus_read(pll_cal_pkg::SYNC_DELAY_ADDR, rd);
        check(rd, 32'h00000028);
        update();
        check({29'h0, ref_delay_o}, 32'h00000005);
        for (int r = 0; r < 4; r++) begin
            bus_write(pll_cal_pkg::LOCK_CAL_CTRL_ADDR, 8'(r << 1));
            update();
            cal_period(per);
            check(32'(per), 32'(2 << r));
        end
        bus_write(pll_cal_pkg::LOCK_CAL_CTRL_ADDR, 8'h08);
        update();
        phase_frames(0, 1);
        check({31'h0, locked_o}, 32'h00000000);
        n_start = 0;
        n_busy = 0;
        bus_write(pll_cal_pkg::LOCK_CAL_CTRL_ADDR, 8'h09);
        update();
        repeat (60) @(posedge ref_clk_i);
        check(32'(n_start), 32'h00000001);
        check(32'(n_busy >= 2 * pll_cal_pkg::CAL_TICKS - 2), 32'h00000001);
        check(32'(n_busy <= 2 * pll_cal_pkg::CAL_TICKS + 2), 32'h00000001);
        bus_read(pll_cal_pkg::STATUS_ADDR, rd);
        check(rd & 32'h00000006, 32'h00000004);
        update();
        repeat (8) @(posedge ref_clk_i);
        check(32'(n_start), 32'h00000001);
        bus_write(pll_cal_pkg::LOCK_CAL_CTRL_ADDR, 8'h06);
        update();
        phase_frames(0, 3);
        check({31'h0, locked_o}, 32'h00000001);
        phase_frames(6, 2);
        check({31'h0, locked_o}, 32'h00000000);
        phase_frames(1, 3);
        check({31'h0, locked_o}, 32'h00000001);
        bus_write(pll_cal_pkg::LOCK_CAL_CTRL_ADDR, 8'h0E);
        update();
        phase_frames(0, 3);
        check({31'h0, locked_o}, 32'h00000000);
        bus_write(pll_cal_pkg::LOCK_CAL_CTRL_ADDR, 8'h16);
        update();
        phase_frames(0, 3);
        check({31'h0, locked_o}, 32'h00000001);
        check({31'h0, lock_window_o}, 32'h00000001);
        for (int m = 0; m < 4; m++) begin
            bus_write(pll_cal_pkg::SYNC_DELAY_ADDR, 8'(m << 6));
            update();
            n_srst = 0;
            n_arst = 0;
            @(posedge ref_clk_i);
            sync_n_i <= 1'b0;
            repeat (12) @(posedge ref_clk_i);
            sync_n_i <= 1'b1;
            repeat (8) @(posedge ref_clk_i);
            check(32'(n_srst), 32'(m == 2));
            check(32'(n_arst != 0), 32'(m == 1));
        end
        tally_and_finish();
    end
endmodule
